// File: hdl/sfh_pkg.sv
package sfh_pkg;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ = 125;
    localparam int LOCKOUT_GRACE_US = 50;
    localparam int LOCKOUT_GRACE_CYC = LOCKOUT_GRACE_US * CLK_MHZ;
    localparam int SOFTSTART_MS_X10 = 48;
    localparam int SOFTSTART_CYC = SOFTSTART_MS_X10 * CLK_MHZ * 100;
    localparam int OVERLOAD_MS = 118;
    localparam int OVERLOAD_CYC = OVERLOAD_MS * CLK_MHZ * 1000;
    // ------------------------------------------------------------
    // levels
    // ------------------------------------------------------------
    localparam int LVL_W = 10;
    localparam logic [9:0] SS_FULL = 10'h3ff;
    localparam int FB_DIV = 3;
    localparam logic [1:0] ARRIVALS_TO_RESTART = 2'h2;
    // ------------------------------------------------------------
    // states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_INHIBIT = 3'b000,
        ST_CHARGE = 3'b001,
        ST_RUN = 3'b010,
        ST_GRACE = 3'b011,
        ST_HICCUP = 3'b100
    } sfh_state_type;
endpackage

// File: hdl/sfh_softstart.sv
`timescale 1ns/1ps
module sfh_softstart #(
    parameter int RAMP_CYC = sfh_pkg::SOFTSTART_CYC,
    parameter int W = sfh_pkg::LVL_W
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic restart,
    input wire logic [W-1:0] feedback_input,
    output logic [W-1:0] softstart_level,
    output logic [W-1:0] modulation_level
);
    localparam int STEP = (RAMP_CYC / (1 << W)) < 1 ? 1 : RAMP_CYC / (1 << W);
    logic [31:0] div_ff, nxt_div;
    logic [W-1:0] lvl_ff, nxt_lvl;
    logic [W-1:0] mod_ff, nxt_mod;
    logic [W-1:0] fb_third;
    // ------------------------------------------------------------
    // ramp 0 to full over the period, then hold
    // ------------------------------------------------------------
    always_comb begin
        nxt_div = div_ff;
        nxt_lvl = lvl_ff;
        fb_third = W'(feedback_input / W'(sfh_pkg::FB_DIV));
        if (restart) begin
            nxt_div = '0;
            nxt_lvl = '0;
        end else if (lvl_ff != sfh_pkg::SS_FULL) begin
            if (div_ff >= 32'(STEP - 1)) begin
                nxt_div = '0;
                nxt_lvl = lvl_ff + W'(1);
            end else begin
                nxt_div = div_ff + 32'h1;
            end
        end
        nxt_mod = (lvl_ff < fb_third) ? lvl_ff : fb_third;
    end
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            div_ff <= '0;
            lvl_ff <= '0;
            mod_ff <= '0;
        end else begin
            div_ff <= nxt_div;
            lvl_ff <= nxt_lvl;
            mod_ff <= nxt_mod;
        end
    end
    assign softstart_level = lvl_ff;
    assign modulation_level = mod_ff;
endmodule

// File: hdl/startup_fault_hiccup_sequencer.sv
`timescale 1ns/1ps
// Overview of operation
// - startup source off at startup-on level
// - source back on at minimum level
// - lockout level stops gate drive immediately
// - recover within grace timer else hiccup
// - four causes enter double hiccup
// - hiccup: drive off, discharge to hiccup
// - two cycles, no restart first arrival
// - soft-start on second arrival
// - persisting fault or latch keeps hiccuping
// - latch held until logic reset level
// - latching variant: long overload latches
// - auto-retry variant resumes after hiccups
// - guard current below inhibit level
// - soft-start ramps to full, holds
// - modulation is min of ramp, fb/3
// - overload counts only after timer
module startup_fault_hiccup_sequencer #(
    parameter bit AUTO_RETRY = 1'b0,
    parameter int GRACE_CYC = sfh_pkg::LOCKOUT_GRACE_CYC,
    parameter int OVLD_CYC = sfh_pkg::OVERLOAD_CYC,
    parameter int SS_CYC = sfh_pkg::SOFTSTART_CYC,
    parameter int W = sfh_pkg::LVL_W
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic above_guard_level,
    input wire logic above_startup_on,
    input wire logic above_min_operating,
    input wire logic above_lockout,
    input wire logic above_hiccup_level,
    input wire logic above_logic_reset,
    input wire logic thermal_fault,
    input wire logic external_latch_fault,
    input wire logic overload,
    input wire logic [W-1:0] feedback_input,
    output logic startup_source_en,
    output logic guard_charge_current,
    output logic gate_drive_out,
    output logic low_current_mode,
    output logic latched_fault,
    output logic [W-1:0] softstart_level,
    output logic [W-1:0] modulation_level
);
    sfh_pkg::sfh_state_type st_ff, nxt_st;
    logic src_ff, nxt_src;
    logic latch_ff, nxt_latch;
    logic [1:0] arr_ff, nxt_arr;
    logic [31:0] grace_ff, nxt_grace;
    logic [31:0] ovld_ff, nxt_ovld;
    logic on_d_ff, nxt_on_d;
    logic restart;
    logic ovld_exp;
    logic fault_now;
    logic on_rise;

    // ------------------------------------------------------------
    // fault qualification
    // ------------------------------------------------------------
    always_comb begin
        // inputs already synchronous; levels used directly, edges from registered copy
        on_rise = above_startup_on & ~on_d_ff;
        nxt_on_d = above_startup_on;
        ovld_exp = (ovld_ff >= 32'(OVLD_CYC));
        nxt_ovld = overload ? (ovld_exp ? ovld_ff : ovld_ff + 32'h1) : 32'h0;
        fault_now = thermal_fault | external_latch_fault | (AUTO_RETRY & ovld_exp);
    end

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    always_comb begin
        nxt_st = st_ff;
        nxt_src = src_ff;
        nxt_latch = latch_ff;
        nxt_arr = arr_ff;
        nxt_grace = grace_ff;
        restart = 1'b0;
        if (!AUTO_RETRY && ovld_exp) begin
            nxt_latch = 1'b1;
        end
        case (st_ff)
            sfh_pkg::ST_INHIBIT: begin
                nxt_src = 1'b0;
                if (above_guard_level) begin
                    nxt_src = 1'b1;
                    nxt_st = sfh_pkg::ST_CHARGE;
                end
            end
            sfh_pkg::ST_CHARGE: begin
                if (!above_guard_level) begin
                    nxt_src = 1'b0;
                    nxt_st = sfh_pkg::ST_INHIBIT;
                end else if (on_rise) begin
                    nxt_src = 1'b0;
                    if (fault_now || latch_ff) begin
                        nxt_st = sfh_pkg::ST_HICCUP;
                        nxt_arr = 2'h0;
                    end else begin
                        restart = 1'b1;
                        nxt_st = sfh_pkg::ST_RUN;
                    end
                end
            end
            sfh_pkg::ST_RUN: begin
                if (!above_min_operating) begin
                    nxt_src = 1'b1;
                end else if (above_startup_on) begin
                    nxt_src = 1'b0;
                end
                if (fault_now || nxt_latch) begin
                    nxt_st = sfh_pkg::ST_HICCUP;
                    nxt_src = 1'b0;
                    nxt_arr = 2'h0;
                end else if (!above_lockout) begin
                    nxt_st = sfh_pkg::ST_GRACE;
                    nxt_grace = 32'h0;
                end
            end
            sfh_pkg::ST_GRACE: begin
                nxt_src = 1'b1;
                nxt_grace = grace_ff + 32'h1;
                if (fault_now || nxt_latch) begin
                    nxt_st = sfh_pkg::ST_HICCUP;
                    nxt_src = 1'b0;
                    nxt_arr = 2'h0;
                end else if (above_lockout) begin
                    nxt_st = sfh_pkg::ST_RUN;
                end else if (grace_ff >= 32'(GRACE_CYC - 1)) begin
                    nxt_st = sfh_pkg::ST_HICCUP;
                    nxt_src = 1'b0;
                    nxt_arr = 2'h0;
                end
            end
            sfh_pkg::ST_HICCUP: begin
                // low current: source off until supply sags to hiccup level
                if (!above_hiccup_level) begin
                    nxt_src = 1'b1;
                end else if (on_rise) begin
                    nxt_src = 1'b0;
                    nxt_arr = arr_ff + 2'h1;
                    if (arr_ff + 2'h1 >= sfh_pkg::ARRIVALS_TO_RESTART) begin
                        nxt_arr = 2'h0;
                        if (!fault_now && !latch_ff) begin
                            restart = 1'b1;
                            nxt_st = sfh_pkg::ST_RUN;
                        end
                    end
                end
            end
            default: begin
                nxt_st = sfh_pkg::ST_INHIBIT;
                nxt_src = 1'b0;
            end
        endcase
        // latch survives hiccup; only the logic reset level clears it
        if (!above_logic_reset) begin
            nxt_latch = 1'b0;
            nxt_arr = 2'h0;
            nxt_src = 1'b0;
            nxt_st = sfh_pkg::ST_INHIBIT;
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            st_ff <= sfh_pkg::ST_INHIBIT;
            src_ff <= 1'b0;
            latch_ff <= 1'b0;
            arr_ff <= 2'h0;
            grace_ff <= 32'h0;
            ovld_ff <= 32'h0;
            on_d_ff <= 1'b0;
        end else begin
            st_ff <= nxt_st;
            src_ff <= nxt_src;
            latch_ff <= nxt_latch;
            arr_ff <= nxt_arr;
            grace_ff <= nxt_grace;
            ovld_ff <= nxt_ovld;
            on_d_ff <= nxt_on_d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // drive is cut combinationally on lockout so it stops the same cycle
    assign gate_drive_out = (st_ff == sfh_pkg::ST_RUN) & above_lockout;
    assign startup_source_en = src_ff;
    assign guard_charge_current = (st_ff == sfh_pkg::ST_INHIBIT);
    assign low_current_mode = (st_ff == sfh_pkg::ST_HICCUP);
    assign latched_fault = latch_ff;

    sfh_softstart #(
        .RAMP_CYC(SS_CYC),
        .W(W)
    ) u_ss (
        .mclk(mclk),
        .resetn(resetn),
        .restart(restart),
        .feedback_input(feedback_input),
        .softstart_level(softstart_level),
        .modulation_level(modulation_level)
    );
endmodule

// File: tb/sfh_checker_assertions.sv
`timescale 1ns/1ps
// ----
// port checker
// ----
module sfh_checker #(
    parameter int W = 10
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic above_guard_level,
    input wire logic above_startup_on,
    input wire logic above_min_operating,
    input wire logic above_lockout,
    input wire logic above_logic_reset,
    input wire logic thermal_fault,
    input wire logic [W-1:0] feedback_input,
    input wire logic startup_source_en,
    input wire logic gate_drive_out,
    input wire logic low_current_mode,
    input wire logic latched_fault,
    input wire logic [W-1:0] softstart_level,
    input wire logic [W-1:0] modulation_level
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!resetn);
    a_src_off_arrival: assert property ($rose(above_startup_on) |=> !startup_source_en)
        else $error("source on after arrival");
    // a fault entry at the same edge takes the hiccup path instead
    a_src_on_min: assert property (gate_drive_out && !above_min_operating
        |=> startup_source_en || low_current_mode)
        else $error("source off below minimum");
    a_gate_lockout: assert property (!above_lockout |-> !gate_drive_out)
        else $error("drive on below lockout");
    a_fault_stops_drive: assert property (thermal_fault |=> !gate_drive_out)
        else $error("drive on during fault");
    a_hiccup_no_drive: assert property (low_current_mode |-> !gate_drive_out)
        else $error("drive on in hiccup");
    a_latch_hold: assert property (latched_fault && above_logic_reset |=> latched_fault)
        else $error("latch lost");
    a_latch_clear: assert property (!above_logic_reset |=> !latched_fault)
        else $error("latch kept at logic reset");
    a_latch_no_drive: assert property (latched_fault |-> !gate_drive_out)
        else $error("drive on while latched");
    a_guard_only: assert property (!above_guard_level |=> !startup_source_en)
        else $error("source on below guard");
    a_mod_min: assert property ((softstart_level == sfh_pkg::SS_FULL
        && $stable(feedback_input)) [*2] |-> modulation_level == feedback_input / 3)
        else $error("modulation not feedback third");
    c_latch: cover property ($rose(latched_fault));
    c_hiccup: cover property ($rose(low_current_mode));
    c_drive: cover property ($rose(gate_drive_out));
endmodule

bind startup_fault_hiccup_sequencer sfh_checker #(.W(W)) u_chk (.mclk(mclk), .resetn(resetn),
    .above_guard_level(above_guard_level), .above_startup_on(above_startup_on),
    .above_min_operating(above_min_operating), .above_lockout(above_lockout),
    .above_logic_reset(above_logic_reset), .thermal_fault(thermal_fault),
    .feedback_input(feedback_input), .startup_source_en(startup_source_en),
    .gate_drive_out(gate_drive_out), .low_current_mode(low_current_mode),
    .latched_fault(latched_fault), .softstart_level(softstart_level),
    .modulation_level(modulation_level));

// File: tb/sfh_supply_model.sv
`timescale 1ns/1ps
// ----
// supply capacitor and comparators
// ----
module sfh_supply_model (
    input wire logic mclk,
    input wire logic charge,
    input wire logic sag,
    input wire logic unplug,
    output logic [5:0] flags = 6'h00
);
    int v = 0;
    // all loads lumped into one unit of drain; sag adds two more
    always @(posedge mclk) begin
        if (unplug) begin
            v <= (v > 0) ? v - 1 : 0;
        end else if (v + (charge ? 2 : 0) > (sag ? 3 : 1)) begin
            v <= v + (charge ? 2 : 0) - (sag ? 3 : 1);
        end else begin
            v <= 0;
        end
        flags <= {v > 40, v > 57, v > 94, v > 99, v > 126, v > 6};
    end
endmodule

// File: tb/tb_startup_fault_hiccup_sequencer.sv
`timescale 1ns/1ps
module tb_startup_fault_hiccup_sequencer;
    typedef struct {logic [24:0] v; logic [24:0] m;} sfh_note_type;
    logic mclk = 1'b0, resetn = 1'b0, sag = 1'b0, unplug = 1'b0;
    logic thermal_fault = 1'b0, external_latch_fault = 1'b0, overload = 1'b0;
    logic [9:0] feedback_input = 10'h3ff;
    logic [9:0] ss, mod;
    logic [5:0] flags;
    logic src, guard, gate, low, latch;
    logic ovl_ar = 1'b0;
    logic [5:0] flags_ar;
    logic [9:0] ss_ar, mod_ar;
    logic src_ar, guard_ar, gate_ar, low_ar, latch_ar;
    wire [4:0] obs_ar = {guard_ar, gate_ar, src_ar, latch_ar, low_ar};
    sfh_note_type q[$];
    sfh_note_type t;
    event ev;
    int mismatches = 0, compares = 0, n;
    wire [24:0] obs = {ss, mod, guard, gate, src, latch, low};
    startup_fault_hiccup_sequencer #(.AUTO_RETRY(1'b0), .GRACE_CYC(8), .OVLD_CYC(50),
        .SS_CYC(1024)) dut (.mclk(mclk), .resetn(resetn), .above_guard_level(flags[0]),
        .above_startup_on(flags[1]), .above_min_operating(flags[2]),
        .above_lockout(flags[3]), .above_hiccup_level(flags[4]),
        .above_logic_reset(flags[5]), .thermal_fault(thermal_fault),
        .external_latch_fault(external_latch_fault), .overload(overload),
        .feedback_input(feedback_input), .startup_source_en(src),
        .guard_charge_current(guard), .gate_drive_out(gate), .low_current_mode(low),
        .latched_fault(latch), .softstart_level(ss), .modulation_level(mod));
    sfh_supply_model u_sup (.mclk(mclk), .charge(src | guard), .sag(sag), .unplug(unplug),
        .flags(flags));
    // auto-retry variant on its own supply
    startup_fault_hiccup_sequencer #(.AUTO_RETRY(1'b1), .GRACE_CYC(8), .OVLD_CYC(50),
        .SS_CYC(1024)) dut_ar (.mclk(mclk), .resetn(resetn), .above_guard_level(flags_ar[0]),
        .above_startup_on(flags_ar[1]), .above_min_operating(flags_ar[2]),
        .above_lockout(flags_ar[3]), .above_hiccup_level(flags_ar[4]),
        .above_logic_reset(flags_ar[5]), .thermal_fault(thermal_fault),
        .external_latch_fault(external_latch_fault), .overload(ovl_ar),
        .feedback_input(feedback_input), .startup_source_en(src_ar),
        .guard_charge_current(guard_ar), .gate_drive_out(gate_ar), .low_current_mode(low_ar),
        .latched_fault(latch_ar), .softstart_level(ss_ar), .modulation_level(mod_ar));
    sfh_supply_model u_sup_ar (.mclk(mclk), .charge(src_ar | guard_ar), .sag(1'b0),
        .unplug(unplug), .flags(flags_ar));
    initial begin
        forever #4 mclk = ~mclk;
    end
    task results();
        $display("mismatches=%0d compares=%0d", mismatches, compares);
        if (mismatches == 0 && compares > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task cmp(input logic [24:0] e, input logic [24:0] g);
        compares++;
        if (e !== g) begin
            mismatches++;
            $display("[FAIL] t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask
    task note(input logic [24:0] v, input logic [24:0] m);
        q.push_back('{v, m});
        ->ev;
    endtask
    initial begin
        forever begin
            @ev;
            while (q.size() > 0) begin
                t = q.pop_front();
                cmp(t.v & t.m, obs & t.m);
            end
        end
    end
    task cyc(input int k);
        repeat (k) @(posedge mclk);
        #1;
    endtask
    task wait_bit(input int i, input logic l, input int lim);
        for (int c = 0; obs[i] !== l; c++) begin
            if (c == lim) begin
                mismatches++;
                $display("[FAIL] t=%0t exp=%h got=%h", $time, l, obs[i]);
                results();
            end
            cyc(1);
        end
    endtask
    task wait_ar(input int i, input logic l, input int lim);
        for (int c = 0; obs_ar[i] !== l; c++) begin
            if (c == lim) begin
                mismatches++;
                $display("[FAIL] t=%0t exp=%h got=%h", $time, l, obs_ar[i]);
                results();
            end
            cyc(1);
        end
    endtask
    // counts startup-on arrivals until drive comes back
    task count_restart(output int a);
        logic p;
        a = 0;
        for (int c = 0; gate !== 1'b1; c++) begin
            if (c == 3000) begin
                mismatches++;
                $display("[FAIL] t=%0t exp=%h got=%h", $time, 1'b1, gate);
                results();
            end
            p = flags[1];
            cyc(1);
            a += (flags[1] && !p) ? 1 : 0;
        end
    endtask
    initial begin
        n = $urandom(32'h4562);
        cyc(1);
        note(25'h10, 25'h1f);
        cyc(2);
        resetn = 1'b1;
        wait_bit(3, 1'b1, 400);
        note(25'h08, 25'h1f);
        wait_bit(2, 1'b1, 100);
        note(25'h0c, 25'h1f);
        cyc(1100);
        note({10'h3ff, 15'h0}, 25'h1ff8000);
        for (int i = 0; i < 4; i++) begin
            feedback_input = 10'($urandom);
            cyc(3);
            note({10'h0, feedback_input / 10'h3, 5'h0}, 25'h7fe0);
        end
        $display("test startup and ramp done");
        sag = 1'b1;
        wait_bit(3, 1'b0, 200);
        note(25'h0, 25'h08);
        sag = 1'b0;
        wait_bit(3, 1'b1, 20);
        note(25'h08, 25'h08);
        for (int k = 0; k < 2; k++) begin
            if (k == 0) sag = 1'b1;
            else thermal_fault = 1'b1;
            wait_bit(0, 1'b1, 300);
            note(25'h01, 25'h09);
            sag = 1'b0;
            thermal_fault = 1'b0;
            count_restart(n);
            cmp(25'h2, 25'(n));
        end
        thermal_fault = 1'b1;
        cyc(700);
        note(25'h0, 25'h08);
        thermal_fault = 1'b0;
        count_restart(n);
        $display("test hiccup done");
        wait_ar(3, 1'b1, 600);
        ovl_ar = 1'b1;
        wait_ar(0, 1'b1, 80);
        cmp(25'h01, {20'h0, obs_ar & 5'h0b});
        ovl_ar = 1'b0;
        wait_ar(3, 1'b1, 600);
        cmp(25'h08, {20'h0, obs_ar & 5'h0b});
        $display("test auto-retry done");
        overload = 1'b1;
        cyc(40);
        overload = 1'b0;
        cyc(2);
        note(25'h08, 25'h0a);
        overload = 1'b1;
        wait_bit(1, 1'b1, 80);
        note(25'h02, 25'h0a);
        overload = 1'b0;
        cyc(800);
        note(25'h02, 25'h0a);
        unplug = 1'b1;
        wait_bit(4, 1'b1, 400);
        note(25'h10, 25'h12);
        unplug = 1'b0;
        wait_bit(3, 1'b1, 600);
        note(25'h08, 25'h0a);
        external_latch_fault = 1'b1;
        cyc(2);
        note(25'h01, 25'h09);
        $display("test latch done");
        results();
    end
endmodule
